/* include/pdt_pkg.sv */
// Package: register map, field layout and constants of the port tag block
package pdt_pkg;

    // Port numbering
    localparam int          NUM_PORTS      = 7;
    localparam int          LAST_PHY_PORT  = 5;
    localparam logic [3:0]  PORT_MIN       = 4'h1;
    localparam logic [3:0]  PORT_MAX       = 4'h7;

    // Offsets inside each 0xN000 port block
    localparam logic [11:0] OFF_TAG_UPPER  = 12'h000;
    localparam logic [11:0] OFF_TAG_LOWER  = 12'h001;
    localparam logic [11:0] OFF_WAKE_EVENT = 12'h013;
    localparam logic [11:0] OFF_WAKE_EN    = 12'h017;

    // Address split: port in the top nibble
    localparam int          ADDR_W         = 16;
    localparam int          PORT_LSB       = 12;

    // Reset values
    localparam logic [7:0]  TAG_UPPER_RST  = 8'h00;
    localparam logic [7:0]  TAG_LOWER_RST  = 8'h01;
    localparam logic [2:0]  WAKE_RST       = 3'h0;

    // Upper tag byte fields
    localparam int          PCP_MSB        = 7;
    localparam int          PCP_LSB        = 5;
    localparam int          DEI_BIT        = 4;
    localparam int          VIDH_MSB       = 3;

    // Wake-event bit positions
    localparam int          EV_MAGIC       = 2;
    localparam int          EV_LINK        = 1;
    localparam int          EV_ENERGY      = 0;
    localparam int          EV_W           = 3;

    // Magic packet shape
    localparam logic [7:0]  SYNC_BYTE      = 8'hFF;
    localparam logic [2:0]  SYNC_COUNT     = 3'h6;
    localparam logic [2:0]  MAC_BYTES      = 3'h6;
    localparam logic [4:0]  MAC_REPEATS    = 5'h10;

endpackage

/* rtl/pdt_magic_det.sv */
// Per-port magic packet detector on the receive byte stream
module pdt_magic_det
    import pdt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Receive byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_last,
    input  wire logic        rx_err,
    // Global switch MAC address, byte 0 in bits 47:40
    input  wire logic [47:0] mac_addr,
    // One-cycle pulse on a good magic frame
    output logic             detect
);

    logic [2:0] pos_reg,   pos_next;
    logic       da_ok_reg, da_ok_next;
    logic [2:0] ff_reg,    ff_next;
    logic [2:0] mi_reg,    mi_next;
    logic [4:0] rep_reg,   rep_next;
    logic       found_reg, found_next;
    logic       detect_reg;

    wire logic [7:0] da_byte  = mac_addr[47 - 8 * pos_reg -: 8];
    wire logic [7:0] exp_byte = mac_addr[47 - 8 * mi_reg -: 8];
    wire logic       is_sync  = (rx_data == SYNC_BYTE);
    wire logic       in_da    = (pos_reg < MAC_BYTES);

    always_comb
    begin
        pos_next   = pos_reg;
        da_ok_next = da_ok_reg;
        ff_next    = ff_reg;
        mi_next    = mi_reg;
        rep_next   = rep_reg;
        found_next = found_reg;
        if (rx_valid)
        begin
            if (in_da)
            begin
                // Destination must equal the switch address
                da_ok_next = da_ok_reg & (rx_data == da_byte);
                pos_next   = pos_reg + 3'h1;
            end
            else if (!found_reg)
            begin
                if (ff_reg == SYNC_COUNT)
                begin
                    // Sixteen copies of the address after the sync
                    if (rx_data == exp_byte)
                    begin
                        if (mi_reg == MAC_BYTES - 3'h1)
                        begin
                            mi_next  = 3'h0;
                            rep_next = rep_reg + 5'h1;
                            if (rep_reg == MAC_REPEATS - 5'h1)
                                found_next = 1'b1;
                        end
                        else
                            mi_next = mi_reg + 3'h1;
                    end
                    else if (!(is_sync && mi_reg == 3'h0 && rep_reg == 5'h0))
                    begin
                        ff_next  = is_sync ? 3'h1 : 3'h0;
                        mi_next  = 3'h0;
                        rep_next = 5'h0;
                    end
                end
                else
                    ff_next = is_sync ? ff_reg + 3'h1 : 3'h0;
            end
        end
    end

    // Frame state restarts after the last byte
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pos_reg    <= 3'h0;
            da_ok_reg  <= 1'b1;
            ff_reg     <= 3'h0;
            mi_reg     <= 3'h0;
            rep_reg    <= 5'h0;
            found_reg  <= 1'b0;
            detect_reg <= 1'b0;
        end
        else
        begin
            // Only error-free frames report
            detect_reg <= rx_valid & rx_last & ~rx_err
                          & da_ok_next & found_next;
            if (rx_valid && rx_last)
            begin
                pos_reg   <= 3'h0;
                da_ok_reg <= 1'b1;
                ff_reg    <= 3'h0;
                mi_reg    <= 3'h0;
                rep_reg   <= 5'h0;
                found_reg <= 1'b0;
            end
            else
            begin
                pos_reg   <= pos_next;
                da_ok_reg <= da_ok_next;
                ff_reg    <= ff_next;
                mi_reg    <= mi_next;
                rep_reg   <= rep_next;
                found_reg <= found_next;
            end
        end
    end

    assign detect = detect_reg;

endmodule

/* rtl/pdt_port_regs.sv */
// Per-port default tag and wake-event registers with wake pin
module pdt_port_regs
    import pdt_pkg::*;
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Management register port
    input  wire logic [ADDR_W-1:0]             reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rdata,
    output logic                               reg_rvalid,
    // Global switch MAC address
    input  wire logic [47:0]                   mac_addr,
    // Receive byte streams, one lane per port
    input  wire logic [NUM_PORTS:1]            rx_valid,
    input  wire logic [NUM_PORTS:1][7:0]       rx_data,
    input  wire logic [NUM_PORTS:1]            rx_last,
    input  wire logic [NUM_PORTS:1]            rx_err,
    // PHY status levels, asynchronous
    input  wire logic [NUM_PORTS:1]            link_up,
    input  wire logic [NUM_PORTS:1]            cable_energy,
    // Default tags and wake output
    output logic      [NUM_PORTS:1][15:0]      default_tag,
    output logic                               power_wake_pin
);

    // Register arrays
    logic [NUM_PORTS:1][7:0]      tag_hi_reg;
    logic [NUM_PORTS:1][7:0]      tag_lo_reg;
    logic [NUM_PORTS:1][EV_W-1:0] event_reg;
    logic [NUM_PORTS:1][EV_W-1:0] event_next;
    logic [NUM_PORTS:1][EV_W-1:0] wake_en_reg;
    logic [7:0]                   rdata_reg;
    logic                         rvalid_reg;
    logic                         wake_reg;

    // Synchronisers and filtered levels
    logic [NUM_PORTS:1] link_s1, link_s2, link_s3, link_lvl;
    logic [NUM_PORTS:1] nrg_s1,  nrg_s2,  nrg_s3,  nrg_lvl;
    logic [NUM_PORTS:1] magic_hit;

    // Address decode
    wire logic [3:0]  acc_port = reg_addr[ADDR_W-1:PORT_LSB];
    wire logic [11:0] acc_off  = reg_addr[PORT_LSB-1:0];
    wire logic        port_ok  = (acc_port >= PORT_MIN)
                                 && (acc_port <= PORT_MAX);
    wire logic [2:0]  pidx     = acc_port[2:0];
    wire logic        sel_hi   = port_ok && (acc_off == OFF_TAG_UPPER);
    wire logic        sel_lo   = port_ok && (acc_off == OFF_TAG_LOWER);
    wire logic        sel_ev   = port_ok && (acc_off == OFF_WAKE_EVENT);
    wire logic        sel_en   = port_ok && (acc_off == OFF_WAKE_EN);

    // Read selection; reserved bits and unmapped offsets read zero
    wire logic [7:0]  rd_mux   =
        sel_hi ? tag_hi_reg[pidx] :
        sel_lo ? tag_lo_reg[pidx] :
        sel_ev ? {5'h00, event_reg[pidx]} :
        sel_en ? {5'h00, wake_en_reg[pidx]} :
                 8'h00;

    // Ports 1 to 5 carry a PHY; 6 and 7 are MAC-only
    wire logic [NUM_PORTS:1] phy_port =
        NUM_PORTS'((1 << LAST_PHY_PORT) - 1);

    // Filtered level follows stage three once stages two and three agree
    wire logic [NUM_PORTS:1] link_agree    = ~(link_s2 ^ link_s3);
    wire logic [NUM_PORTS:1] nrg_agree     = ~(nrg_s2 ^ nrg_s3);
    wire logic [NUM_PORTS:1] link_lvl_next =
        (link_agree & link_s3) | (~link_agree & link_lvl);
    wire logic [NUM_PORTS:1] nrg_lvl_next  =
        (nrg_agree & nrg_s3) | (~nrg_agree & nrg_lvl);

    // A rise counts once, on the cycle the filtered level goes high
    wire logic [NUM_PORTS:1] link_rise =
        link_lvl_next & ~link_lvl & phy_port;
    wire logic [NUM_PORTS:1] nrg_rise  =
        nrg_lvl_next & ~nrg_lvl & phy_port;

    genvar p;
    generate
        for (p = 1; p <= NUM_PORTS; p++)
        begin : g_port
            wire logic            wr_here  = reg_wr && (pidx == 3'(p));
            wire logic            ev_magic = magic_hit[p];
            wire logic            ev_link  = link_rise[p];
            wire logic            ev_nrg   = nrg_rise[p];
            wire logic [EV_W-1:0] ev_set   = {ev_magic, ev_link, ev_nrg};
            wire logic [EV_W-1:0] ev_clr   =
                (wr_here && sel_ev) ? reg_wdata[EV_W-1:0] : '0;

            // Set beats a same-cycle one-to-clear write
            assign event_next[p] = (event_reg[p] & ~ev_clr)
                                   | ev_set;

            pdt_magic_det u_magic
            (
                .clk      (clk),
                .rst      (rst),
                .rx_valid (rx_valid[p]),
                .rx_data  (rx_data[p]),
                .rx_last  (rx_last[p]),
                .rx_err   (rx_err[p]),
                .mac_addr (mac_addr),
                .detect   (magic_hit[p])
            );

            // Upper tag byte
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    tag_hi_reg[p] <= TAG_UPPER_RST;
                else if (wr_here && sel_hi)
                    tag_hi_reg[p] <= reg_wdata;
            end

            // Lower tag byte
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    tag_lo_reg[p] <= TAG_LOWER_RST;
                else if (wr_here && sel_lo)
                    tag_lo_reg[p] <= reg_wdata;
            end

            // Wake enables
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    wake_en_reg[p] <= WAKE_RST;
                else if (wr_here && sel_en)
                    wake_en_reg[p] <= reg_wdata[EV_W-1:0];
            end

            // Event flags
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    event_reg[p] <= WAKE_RST;
                else
                    event_reg[p] <= event_next[p];
            end

            // Tag fields: PCP, DEI, VID[11:8] above VID[7:0]
            assign default_tag[p] = {tag_hi_reg[p][PCP_MSB:PCP_LSB],
                                     tag_hi_reg[p][DEI_BIT],
                                     tag_hi_reg[p][VIDH_MSB:0],
                                     tag_lo_reg[p]};
        end
    endgenerate

    // Three-stage link synchroniser and filtered level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            link_s1  <= '0;
            link_s2  <= '0;
            link_s3  <= '0;
            link_lvl <= '0;
        end
        else
        begin
            link_s1  <= link_up;
            link_s2  <= link_s1;
            link_s3  <= link_s2;
            link_lvl <= link_lvl_next;
        end
    end

    // Three-stage energy synchroniser and filtered level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            nrg_s1  <= '0;
            nrg_s2  <= '0;
            nrg_s3  <= '0;
            nrg_lvl <= '0;
        end
        else
        begin
            nrg_s1  <= cable_energy;
            nrg_s2  <= nrg_s1;
            nrg_s3  <= nrg_s2;
            nrg_lvl <= nrg_lvl_next;
        end
    end

    // Wake pin: any enabled event still pending
    wire logic wake_any = |(event_next & wake_en_reg);

    // Read data one cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= reg_rd;
            if (reg_rd)
                rdata_reg <= rd_mux;
        end
    end

    // Registered wake level; an enable write shows one cycle later
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wake_reg <= 1'b0;
        else
            wake_reg <= wake_any;
    end

    assign reg_rdata      = rdata_reg;
    assign reg_rvalid     = rvalid_reg;
    assign power_wake_pin = wake_reg;

endmodule

/* verification/pdt_port_regs_sva.sv */
// Checker for the port tag and wake-event register block
module pdt_port_regs_sva
    import pdt_pkg::*;
(
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst,
    // Register port
    input wire logic [ADDR_W-1:0]        reg_addr,
    input wire logic                     reg_wr,
    input wire logic [7:0]               reg_wdata,
    input wire logic                     reg_rd,
    input wire logic [7:0]               reg_rdata,
    input wire logic                     reg_rvalid,
    // Outputs
    input wire logic [NUM_PORTS:1][15:0] default_tag,
    input wire logic                     power_wake_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [2:0]  pn;
    logic        ok;
    logic [11:0] off;
    logic [7:0]  sel;
    assign pn  = reg_addr[14:12];
    assign ok  = !reg_addr[15] && pn != 3'h0;
    assign off = reg_addr[11:0];
    assign sel = default_tag[pn][15:8];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_rvalid;
        reg_rvalid == $past(reg_rd);
    endproperty
    property p_up_wr;
        reg_wr && ok && off == OFF_TAG_UPPER
            |=> default_tag[$past(pn)][15:8] == $past(reg_wdata);
    endproperty
    property p_lo_wr;
        reg_wr && ok && off == OFF_TAG_LOWER
            |=> default_tag[$past(pn)][7:0] == $past(reg_wdata);
    endproperty
    property p_hold;
        !reg_wr |=> $stable(default_tag);
    endproperty
    property p_rd_tag;
        reg_rd && ok && off == OFF_TAG_UPPER |=> reg_rdata == $past(sel);
    endproperty
    property p_resv;
        reg_rd && off == OFF_WAKE_EVENT |=> reg_rdata[7:3] == 5'h00;
    endproperty
    property p_mac;
        reg_rd && reg_addr[15:13] == 3'h3 && off == OFF_WAKE_EVENT
            |=> reg_rdata[1:0] == 2'h0;
    endproperty
    property p_bad;
        reg_rd && !ok |=> reg_rdata == 8'h00;
    endproperty
    property p_pin;
        power_wake_pin && !reg_wr |=> power_wake_pin;
    endproperty

    a_rvalid: assert property (p_rvalid)
        else $error("read valid not one cycle after read");
    a_up_wr: assert property (p_up_wr)
        else $error("upper tag byte not written");
    a_lo_wr: assert property (p_lo_wr)
        else $error("lower tag byte not written");
    a_hold: assert property (p_hold)
        else $error("tag changed without a write");
    a_rd_tag: assert property (p_rd_tag)
        else $error("upper tag read differs from tag output");
    a_resv: assert property (p_resv)
        else $error("reserved event bits not zero");
    a_mac: assert property (p_mac)
        else $error("link or energy flag on a MAC port");
    a_bad: assert property (p_bad)
        else $error("read of invalid port not zero");
    a_pin: assert property (p_pin)
        else $error("wake pin dropped without a write");

    c_pin: cover property ($rose(power_wake_pin));
    c_ev: cover property (reg_rvalid && reg_rdata[2]);
    c_clr: cover property (reg_wr && off == OFF_WAKE_EVENT);
endmodule

/* verification/pdt_port_regs_bench.sv */
// Self-checking bench for the port tag and wake-event register block
module pdt_port_regs_bench
    import pdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                     clk, rst, reg_wr, reg_rd, reg_rvalid;
    logic [ADDR_W-1:0]        reg_addr;
    logic [7:0]               reg_wdata, reg_rdata;
    logic [47:0]              mac_addr;
    logic [NUM_PORTS:1]       rx_valid, rx_last, rx_err, link_up, cable_energy;
    logic [NUM_PORTS:1][7:0]  rx_data;
    logic [NUM_PORTS:1][15:0] default_tag;
    logic                     power_wake_pin;
    int                       num_errors, checks, cycles;

    pdt_port_regs uut (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_rvalid, .mac_addr, .rx_valid, .rx_data, .rx_last,
        .rx_err, .link_up, .cable_energy, .default_tag, .power_wake_pin);

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
            num_errors++;
        end
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("rvalid", 16'h1, reg_rvalid);
        chk($sformatf("rdata %h", a), e, reg_rdata);
    endtask

    // Address, sender, type, six sync bytes, sixteen address copies
    task automatic frame(int p, logic [47:0] da, logic err);
        for (int i = 0; i < 116; i++)
        begin
            @(posedge clk);
            rx_valid[p] <= 1'b1;
            rx_last[p]  <= (i == 115);
            rx_err[p]   <= err & (i == 115);
            rx_data[p]  <= i < 6 ? da[47-8*i -: 8] : i < 12 ? 8'h02 :
                i < 14 ? 8'h08 : i < 20 ? 8'hFF :
                mac_addr[47-8*((i-20)%6) -: 8];
        end
        @(posedge clk);
        rx_valid[p] <= 1'b0;
        rx_last[p]  <= 1'b0;
        rx_err[p]   <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            report_and_stop;
        end
    end

    initial
    begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 26'h0};
        {rx_valid, rx_last, rx_err, rx_data} = '0;
        {link_up, cable_energy} = '0;
        {num_errors, checks, cycles} = '0;
        mac_addr = 48'h02_12_34_56_78_9A;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int p = 1; p <= 7; p++)
        begin
            rd(16'(p) << 12, 8'h00);
            rd((16'(p) << 12) | 16'h0001, 8'h01);
            rd((16'(p) << 12) | 16'h0013, 8'h00);
            chk("tag", 16'h0001, default_tag[p]);
            wr(16'(p) << 12, 8'hA0 | 8'(p));
            wr((16'(p) << 12) | 16'h0001, 8'(p) << 4);
        end
        for (int p = 1; p <= 7; p++)
        begin
            rd(16'(p) << 12, 8'hA0 | 8'(p));
            chk("tag", {8'hA0 | 8'(p), 8'(p) << 4}, default_tag[p]);
        end
        wr(16'h3000, 8'hB5);
        chk("pcp", 16'h0005, default_tag[3][15:13]);
        chk("dei", 16'h0001, default_tag[3][12]);
        chk("vid", 16'h0530, default_tag[3][11:0]);
        wr(16'h0000, 8'hFF);
        wr(16'h8000, 8'hFF);
        rd(16'h0000, 8'h00);
        rd(16'h8000, 8'h00);
        rd(16'h1000, 8'hA1);
        wr(16'h1013, 8'hFF);
        rd(16'h1013, 8'h00);
        wr(16'h2017, 8'h02);
        rd(16'h2017, 8'h02);
        @(posedge clk);
        link_up <= 7'h02;
        repeat (6) @(posedge clk);
        rd(16'h2013, 8'h02);
        chk("pin", 16'h1, power_wake_pin);
        wr(16'h2013, 8'h01);
        rd(16'h2013, 8'h02);
        wr(16'h2013, 8'h02);
        rd(16'h2013, 8'h00);
        chk("pin", 16'h0, power_wake_pin);
        @(posedge clk);
        link_up      <= 7'h62;
        cable_energy <= 7'h61;
        repeat (6) @(posedge clk);
        rd(16'h1013, 8'h01);
        chk("pin", 16'h0, power_wake_pin);
        rd(16'h6013, 8'h00);
        rd(16'h7013, 8'h00);
        frame(4, mac_addr, 1'b0);
        rd(16'h4013, 8'h04);
        frame(5, 48'h02_12_34_56_78_9B, 1'b0);
        rd(16'h5013, 8'h00);
        frame(5, mac_addr, 1'b1);
        rd(16'h5013, 8'h00);
        wr(16'h4017, 8'h04);
        @(negedge clk);
        chk("pin", 16'h1, power_wake_pin);
        report_and_stop;
    end
endmodule

bind pdt_port_regs pdt_port_regs_sva chk (.clk, .rst, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .default_tag,
    .power_wake_pin);
